// *** core/pafm_pad.sv ***
`timescale 1ns/100ps

// =====================================================================
// One pad: input synchroniser and drive mode control
module pafm_pad (
  input wire logic clock, // System clock
  input wire logic rst_n, // Synchronised reset, active low
  input pafm_pkg::pafm_pad_e mode, // Drive mode for this pin
  input wire logic data_out, // Value the pin should show
  input wire logic pin_in, // Raw pin level
  output logic pin_out, // Pad output value
  output logic pin_oe, // Pad output enable, high drives
  output logic pullup_en, // Weak pull-up enable
  output logic pin_level // Synchronised pin level
);

  logic meta_ff;
  logic prev_ff;
  logic nxt_oe;
  logic nxt_out;
  logic nxt_pullup;
  logic rise;

  // =====================================================================
  // Two-stage synchroniser, first stage feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= pafm_pkg::PAD_LEVEL_RESET;
      pin_level <= pafm_pkg::PAD_LEVEL_RESET;
    end else begin
      meta_ff <= pin_in;
      pin_level <= meta_ff;
    end
  end

  // Delayed copy of the data for the 0-to-1 boost
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= pafm_pkg::PAD_PREV_RESET;
    end else begin
      prev_ff <= data_out;
    end
  end

  assign rise = data_out & ~prev_ff;

  // Driver selection per mode
  always_comb begin
    nxt_oe = 1'b0;
    nxt_out = 1'b0;
    nxt_pullup = 1'b1;
    case (mode)
      pafm_pkg::PAD_QUASI: begin
        nxt_oe = ~data_out | rise; // [RULE12]
        nxt_out = data_out;
      end
      pafm_pkg::PAD_OPEN_DRAIN: begin
        nxt_oe = ~data_out; // [RULE13]
      end
      pafm_pkg::PAD_PUSH_PULL: begin
        nxt_oe = 1'b1; // [RULE14]
        nxt_out = data_out;
        nxt_pullup = 1'b0;
      end
      pafm_pkg::PAD_ANALOG: begin
        nxt_pullup = 1'b0; // [RULE15]
      end
      default: begin
        nxt_oe = 1'b0;
      end
    endcase
  end

  // Registered pad controls so outputs never glitch
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_oe <= pafm_pkg::PAD_OE_RESET;
      pin_out <= pafm_pkg::PAD_OUT_RESET;
      pullup_en <= pafm_pkg::PAD_PULLUP_RESET;
    end else begin
      pin_oe <= nxt_oe;
      pin_out <= nxt_out;
      pullup_en <= nxt_pullup;
    end
  end

  // =====================================================================
  // Checks
  property p_boost_rise;
    @(posedge clock) disable iff (!rst_n)
    (mode == pafm_pkg::PAD_QUASI && data_out && !prev_ff)
      |=> (pin_oe && pin_out);
  endproperty
  a_boost_rise: assert property (p_boost_rise) // [RULE12]
    else $error("high side not driven on rise");

  property p_boost_once;
    @(posedge clock) disable iff (!rst_n)
    (mode == pafm_pkg::PAD_QUASI && data_out && !prev_ff) ##1
      (mode == pafm_pkg::PAD_QUASI && data_out) |=> !pin_oe;
  endproperty
  a_boost_once: assert property (p_boost_once) // [RULE12]
    else $error("high side held past one clock");

  property p_open_drain;
    @(posedge clock) disable iff (!rst_n)
    mode == pafm_pkg::PAD_OPEN_DRAIN |=> !(pin_oe && pin_out) && pullup_en;
  endproperty
  a_open_drain: assert property (p_open_drain) // [RULE13]
    else $error("open drain pin drove high");

  property p_push_pull;
    @(posedge clock) disable iff (!rst_n)
    mode == pafm_pkg::PAD_PUSH_PULL |=> pin_oe && pin_out == $past(data_out);
  endproperty
  a_push_pull: assert property (p_push_pull) // [RULE14]
    else $error("push pull pin not driven");

  property p_analog;
    @(posedge clock) disable iff (!rst_n)
    mode == pafm_pkg::PAD_ANALOG |=> !pin_oe && !pullup_en;
  endproperty
  a_analog: assert property (p_analog) // [RULE15]
    else $error("analog pin not released");

endmodule // pafm_pad

// *** core/pafm_pkg.sv ***
// =====================================================================
// Shared constants for the port alternate function mux
package pafm_pkg;

  // =====================================================================
  // Select register addresses on the special function register port
  localparam logic [7:0] ADDR_P1_LO = 8'h8e;
  localparam logic [7:0] ADDR_P1_HI = 8'h8f;
  localparam logic [7:0] ADDR_P3 = 8'h91;
  localparam logic [7:0] ADDR_P4_LO = 8'h92;
  localparam logic [7:0] ADDR_P4_HI = 8'h93;

  // =====================================================================
  // Reset values and fixed read answers
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic IDLE_LEVEL = 1'b1;
  localparam logic [5:0] MODULE_IDLE = 6'h3f;
  localparam logic [7:0] ANALOG_RESET = 8'h00;

  // =====================================================================
  // Pin map: pad index offsets and fixed function masks
  localparam int PORT_W = 8;
  localparam int NUM_PADS = 24;
  localparam int P1_BASE = 0;
  localparam int P3_BASE = 8;
  localparam int P4_BASE = 16;
  localparam logic [7:0] P3_I2C_MASK = 8'hc0;
  localparam int P3_RX_BIT = 0;
  localparam int P3_INT0_BIT = 2;
  localparam int P3_INT1_BIT = 3;
  localparam int P3_CNT0_BIT = 4;
  localparam int P3_CNT1_BIT = 5;
  localparam int P3_SDA_BIT = 6;
  localparam int P3_SCL_BIT = 7;
  localparam int T2_COUNT_BIT = 0;
  localparam int T2_TRIG_BIT = 1;
  localparam int SER1_RX_BIT = 2;
  localparam int SPI_RX_BIT = 5;
  localparam int ARR0_CLK_BIT = 3;
  localparam int ARR1_CLK_BIT = 7;

  // =====================================================================
  // Pad drive modes, Gray coded
  typedef enum logic [1:0] {
    PAD_QUASI = 2'b00,
    PAD_OPEN_DRAIN = 2'b01,
    PAD_PUSH_PULL = 2'b11,
    PAD_ANALOG = 2'b10
  } pafm_pad_e;

  // =====================================================================
  // Pad reset state: released pin with weak pull-up
  localparam logic PAD_OE_RESET = 1'b0;
  localparam logic PAD_OUT_RESET = 1'b0;
  localparam logic PAD_PULLUP_RESET = 1'b1;
  localparam logic PAD_LEVEL_RESET = 1'b1;
  localparam logic PAD_PREV_RESET = 1'b1;

endpackage

// *** core/pafm_top.sv ***
`timescale 1ns/100ps

// Contract
// [RULE1] Port 3 pin is GPIO when its select bit is 0, alternate when 1.
// [RULE2] Port 3 alternates: serial 0 rx/tx, interrupts/gates, counters, I2C.
// [RULE3] Ports 1: lo=0 GPIO, lo=1 hi=0 alternate 1, both 1 alternate 2.
// [RULE4] Port 1 alternate 1: timer 2, serial 1, then four SPI signals.
// [RULE5] Port 1 alternate 2 routes pin i to analog channel i.
// [RULE6] Port 4 same decode; alternate 1 is the two counter arrays.
// [RULE7] Port 4 alternate 2: timer 2, serial 1, then four SPI signals.
// [RULE8] Port 1 low select register at 8Eh, reset zero.
// [RULE9] Port 1 high select register at 8Fh, reset zero.
// [RULE10] Port 4 low select register at 92h, reset zero.
// [RULE11] Port 4 high select register at 93h, reset zero.
// [RULE12] Serial and SPI pins quasi-bidirectional, one-clock high boost on rise.
// [RULE13] I2C pins open drain, never boosted high.
// [RULE14] Counter array outputs on Port 4 drive push-pull.
// [RULE15] Analog pins drop pull-ups and both drivers.
// [RULE16] Peripheral inputs not selected on any pin read idle high.
module pafm_top (
  input wire logic clock, // 25 MHz system clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic [7:0] sfr_addr, // Register address
  input wire logic sfr_wr, // Register write strobe
  input wire logic sfr_rd, // Register read strobe
  input wire logic [7:0] sfr_wdata, // Register write data
  output logic [7:0] sfr_rdata, // Register read data
  input wire logic [7:0] port1_latch, // GPIO data latch, port 1
  input wire logic [7:0] port3_latch, // GPIO data latch, port 3
  input wire logic [7:0] port4_latch, // GPIO data latch, port 4
  input wire logic serial0_transmit, // Serial port 0 transmit data
  input wire logic serial1_transmit, // Serial port 1 transmit data
  input wire logic i2c_data_out, // I2C data, 0 pulls low
  input wire logic i2c_clock_out, // I2C clock, 0 pulls low
  input wire logic spi_clock_out, // SPI clock from controller
  input wire logic spi_transmit_out, // SPI transmit data
  input wire logic spi_select_out, // SPI select, active low
  input wire logic [5:0] array_module_out, // Counter module output data
  input wire logic [5:0] array_module_drive, // Counter module output mode
  output logic serial0_receive, // Serial port 0 receive data
  output logic serial1_receive, // Serial port 1 receive data
  output logic external_interrupt_zero, // Interrupt 0, also timer 0 gate
  output logic external_interrupt_one, // Interrupt 1, also timer 1 gate
  output logic counter0_input, // Counter 0 input
  output logic counter1_input, // Counter 1 input
  output logic i2c_data_in, // I2C data as seen on pin
  output logic i2c_clock_in, // I2C clock as seen on pin
  output logic timer2_count_in, // Timer 2 count input
  output logic timer2_trigger_in, // Timer 2 trigger input
  output logic spi_receive_in, // SPI receive data
  output logic [5:0] array_module_in, // Counter module capture inputs
  output logic array_zero_ext_clock, // Counter array 0 external clock
  output logic array_one_ext_clock, // Counter array 1 external clock
  output logic [7:0] analog_select, // Port 1 pin i to analog channel i
  input wire logic [7:0] port1_pin_in, // Port 1 pad inputs
  output logic [7:0] port1_pin_out, // Port 1 pad outputs
  output logic [7:0] port1_pin_oe, // Port 1 output enables
  output logic [7:0] port1_pullup_en, // Port 1 weak pull-ups
  output logic [7:0] port1_pin_level, // Port 1 synchronised levels
  input wire logic [7:0] port3_pin_in, // Port 3 pad inputs
  output logic [7:0] port3_pin_out, // Port 3 pad outputs
  output logic [7:0] port3_pin_oe, // Port 3 output enables
  output logic [7:0] port3_pullup_en, // Port 3 weak pull-ups
  output logic [7:0] port3_pin_level, // Port 3 synchronised levels
  input wire logic [7:0] port4_pin_in, // Port 4 pad inputs
  output logic [7:0] port4_pin_out, // Port 4 pad outputs
  output logic [7:0] port4_pin_oe, // Port 4 output enables
  output logic [7:0] port4_pullup_en, // Port 4 weak pull-ups
  output logic [7:0] port4_pin_level // Port 4 synchronised levels
);

  // =====================================================================
  // Helpers
  function automatic logic [7:0] mux8(input logic [7:0] sel,
                                      input logic [7:0] alt,
                                      input logic [7:0] dflt);
    mux8 = (sel & alt) | (~sel & dflt);
  endfunction

  // Unselected inputs fall back to the idle high level
  function automatic logic gate_in(input logic level, input logic en);
    gate_in = level | ~en;
  endfunction

  logic rst_meta_ff;
  logic rst_n_ff;
  logic [7:0] p1_lo_ff;
  logic [7:0] p1_hi_ff;
  logic [7:0] p3_sel_ff;
  logic [7:0] p4_lo_ff;
  logic [7:0] p4_hi_ff;
  logic [7:0] a1_p1, a2_p1, a1_p4, a2_p4;
  logic [7:0] shared_data, p3_alt_data, p4_alt1_data, p4_pp;
  logic [7:0] d1, d3, d4;
  logic [5:0] mod_data;
  logic [23:0] pad_data, pad_in, pad_out, pad_oe, pad_pull, pad_lvl;
  pafm_pkg::pafm_pad_e pad_mode [pafm_pkg::NUM_PADS];

  // =====================================================================
  // Reset release through two flops
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // =====================================================================
  // Select registers; all clear so every pin starts as GPIO
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      p1_lo_ff <= pafm_pkg::SEL_RESET;
      p1_hi_ff <= pafm_pkg::SEL_RESET;
      p3_sel_ff <= pafm_pkg::SEL_RESET;
      p4_lo_ff <= pafm_pkg::SEL_RESET;
      p4_hi_ff <= pafm_pkg::SEL_RESET;
    end else if (sfr_wr) begin
      case (sfr_addr)
        pafm_pkg::ADDR_P1_LO: p1_lo_ff <= sfr_wdata; // [RULE8]
        pafm_pkg::ADDR_P1_HI: p1_hi_ff <= sfr_wdata; // [RULE9]
        pafm_pkg::ADDR_P3: p3_sel_ff <= sfr_wdata;
        pafm_pkg::ADDR_P4_LO: p4_lo_ff <= sfr_wdata; // [RULE10]
        pafm_pkg::ADDR_P4_HI: p4_hi_ff <= sfr_wdata; // [RULE11]
        default: p3_sel_ff <= p3_sel_ff;
      endcase
    end
  end

  // Read port; unmapped addresses answer zero
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sfr_rdata <= pafm_pkg::RDATA_RESET;
    end else if (sfr_rd) begin
      case (sfr_addr)
        pafm_pkg::ADDR_P1_LO: sfr_rdata <= p1_lo_ff;
        pafm_pkg::ADDR_P1_HI: sfr_rdata <= p1_hi_ff;
        pafm_pkg::ADDR_P3: sfr_rdata <= p3_sel_ff;
        pafm_pkg::ADDR_P4_LO: sfr_rdata <= p4_lo_ff;
        pafm_pkg::ADDR_P4_HI: sfr_rdata <= p4_hi_ff;
        default: sfr_rdata <= pafm_pkg::UNMAPPED_READ;
      endcase
    end
  end

  // =====================================================================
  // Three-way decode; the high bit is ignored while the low bit is 0
  assign a1_p1 = p1_lo_ff & ~p1_hi_ff; // [RULE3]
  assign a2_p1 = p1_lo_ff & p1_hi_ff; // [RULE3]
  assign a1_p4 = p4_lo_ff & ~p4_hi_ff; // [RULE6]
  assign a2_p4 = p4_lo_ff & p4_hi_ff; // [RULE6]

  // Output data per function; input-only alternates hold 1 (pull-up only)
  assign shared_data = {spi_select_out, spi_transmit_out, 1'b1,
                        spi_clock_out, serial1_transmit, 3'b111}; // [RULE4]
  assign p3_alt_data = {i2c_clock_out, i2c_data_out, 4'hf,
                        serial0_transmit, 1'b1}; // [RULE2]
  assign mod_data = array_module_out | ~array_module_drive;
  assign p4_alt1_data = {1'b1, mod_data[5:3], 1'b1, mod_data[2:0]};
  assign p4_pp = {1'b0, array_module_drive[5:3], 1'b0,
                  array_module_drive[2:0]} & a1_p4; // [RULE14]

  assign d1 = mux8(a1_p1, shared_data, port1_latch); // [RULE4]
  assign d3 = mux8(p3_sel_ff, p3_alt_data, port3_latch); // [RULE1]
  assign d4 = mux8(a1_p4, p4_alt1_data,
                   mux8(a2_p4, shared_data, port4_latch)); // [RULE7]
  assign pad_data = {d4, d3, d1};
  assign pad_in = {port4_pin_in, port3_pin_in, port1_pin_in};

  // Drive mode per pad
  always_comb begin
    for (int i = 0; i < pafm_pkg::PORT_W; i++) begin
      pad_mode[pafm_pkg::P1_BASE + i] = a2_p1[i] ?
        pafm_pkg::PAD_ANALOG : pafm_pkg::PAD_QUASI; // [RULE15]
      pad_mode[pafm_pkg::P3_BASE + i] =
        (p3_sel_ff[i] && pafm_pkg::P3_I2C_MASK[i]) ?
        pafm_pkg::PAD_OPEN_DRAIN : pafm_pkg::PAD_QUASI; // [RULE13]
      pad_mode[pafm_pkg::P4_BASE + i] = p4_pp[i] ?
        pafm_pkg::PAD_PUSH_PULL : pafm_pkg::PAD_QUASI; // [RULE12]
    end
  end

  // =====================================================================
  // Pads
  for (genvar g = 0; g < pafm_pkg::NUM_PADS; g++) begin : g_pad
    pafm_pad u_pad (
      .clock(clock),
      .rst_n(rst_n_ff),
      .mode(pad_mode[g]),
      .data_out(pad_data[g]),
      .pin_in(pad_in[g]),
      .pin_out(pad_out[g]),
      .pin_oe(pad_oe[g]),
      .pullup_en(pad_pull[g]),
      .pin_level(pad_lvl[g])
    );
  end

  assign {port4_pin_out, port3_pin_out, port1_pin_out} = pad_out;
  assign {port4_pin_oe, port3_pin_oe, port1_pin_oe} = pad_oe;
  assign {port4_pullup_en, port3_pullup_en, port1_pullup_en} = pad_pull;
  assign {port4_pin_level, port3_pin_level, port1_pin_level} = pad_lvl;

  // =====================================================================
  // Peripheral inputs; a function split over two ports ANDs both sources
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      serial0_receive <= pafm_pkg::IDLE_LEVEL;
      external_interrupt_zero <= pafm_pkg::IDLE_LEVEL;
      external_interrupt_one <= pafm_pkg::IDLE_LEVEL;
      counter0_input <= pafm_pkg::IDLE_LEVEL;
      counter1_input <= pafm_pkg::IDLE_LEVEL;
      i2c_data_in <= pafm_pkg::IDLE_LEVEL;
      i2c_clock_in <= pafm_pkg::IDLE_LEVEL;
    end else begin
      serial0_receive <= gate_in(port3_pin_level[pafm_pkg::P3_RX_BIT],
        p3_sel_ff[pafm_pkg::P3_RX_BIT]); // [RULE1] [RULE16]
      external_interrupt_zero <= gate_in(
        port3_pin_level[pafm_pkg::P3_INT0_BIT],
        p3_sel_ff[pafm_pkg::P3_INT0_BIT]); // [RULE2]
      external_interrupt_one <= gate_in(
        port3_pin_level[pafm_pkg::P3_INT1_BIT],
        p3_sel_ff[pafm_pkg::P3_INT1_BIT]); // [RULE2]
      counter0_input <= gate_in(port3_pin_level[pafm_pkg::P3_CNT0_BIT],
        p3_sel_ff[pafm_pkg::P3_CNT0_BIT]); // [RULE2]
      counter1_input <= gate_in(port3_pin_level[pafm_pkg::P3_CNT1_BIT],
        p3_sel_ff[pafm_pkg::P3_CNT1_BIT]); // [RULE2]
      i2c_data_in <= gate_in(port3_pin_level[pafm_pkg::P3_SDA_BIT],
        p3_sel_ff[pafm_pkg::P3_SDA_BIT]); // [RULE2]
      i2c_clock_in <= gate_in(port3_pin_level[pafm_pkg::P3_SCL_BIT],
        p3_sel_ff[pafm_pkg::P3_SCL_BIT]); // [RULE2]
    end
  end

  // Timer 2, serial 1 and SPI may sit on port 1 or port 4
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      timer2_count_in <= pafm_pkg::IDLE_LEVEL;
      timer2_trigger_in <= pafm_pkg::IDLE_LEVEL;
      serial1_receive <= pafm_pkg::IDLE_LEVEL;
      spi_receive_in <= pafm_pkg::IDLE_LEVEL;
    end else begin
      timer2_count_in <=
        gate_in(port1_pin_level[pafm_pkg::T2_COUNT_BIT],
                a1_p1[pafm_pkg::T2_COUNT_BIT]) &
        gate_in(port4_pin_level[pafm_pkg::T2_COUNT_BIT],
                a2_p4[pafm_pkg::T2_COUNT_BIT]); // [RULE4] [RULE7]
      timer2_trigger_in <=
        gate_in(port1_pin_level[pafm_pkg::T2_TRIG_BIT],
                a1_p1[pafm_pkg::T2_TRIG_BIT]) &
        gate_in(port4_pin_level[pafm_pkg::T2_TRIG_BIT],
                a2_p4[pafm_pkg::T2_TRIG_BIT]); // [RULE4] [RULE7]
      serial1_receive <=
        gate_in(port1_pin_level[pafm_pkg::SER1_RX_BIT],
                a1_p1[pafm_pkg::SER1_RX_BIT]) &
        gate_in(port4_pin_level[pafm_pkg::SER1_RX_BIT],
                a2_p4[pafm_pkg::SER1_RX_BIT]); // [RULE16]
      spi_receive_in <=
        gate_in(port1_pin_level[pafm_pkg::SPI_RX_BIT],
                a1_p1[pafm_pkg::SPI_RX_BIT]) &
        gate_in(port4_pin_level[pafm_pkg::SPI_RX_BIT],
                a2_p4[pafm_pkg::SPI_RX_BIT]); // [RULE16]
    end
  end

  // Counter arrays and analog channel routing
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      array_module_in <= pafm_pkg::MODULE_IDLE;
      array_zero_ext_clock <= pafm_pkg::IDLE_LEVEL;
      array_one_ext_clock <= pafm_pkg::IDLE_LEVEL;
      analog_select <= pafm_pkg::ANALOG_RESET;
    end else begin
      array_module_in <= {port4_pin_level[6:4] | ~a1_p4[6:4],
        port4_pin_level[2:0] | ~a1_p4[2:0]}; // [RULE6]
      array_zero_ext_clock <= gate_in(
        port4_pin_level[pafm_pkg::ARR0_CLK_BIT],
        a1_p4[pafm_pkg::ARR0_CLK_BIT]); // [RULE6]
      array_one_ext_clock <= gate_in(
        port4_pin_level[pafm_pkg::ARR1_CLK_BIT],
        a1_p4[pafm_pkg::ARR1_CLK_BIT]); // [RULE6]
      analog_select <= a2_p1; // [RULE5]
    end
  end

  // =====================================================================
  // Checks
  property p_p3_rx_route;
    @(posedge clock) disable iff (!rst_n_ff)
    p3_sel_ff[0] |=> serial0_receive == $past(port3_pin_level[0]);
  endproperty
  a_p3_rx_route: assert property (p_p3_rx_route) // [RULE1]
    else $error("port 3 receive not routed");

  property p_p3_idle;
    @(posedge clock) disable iff (!rst_n_ff)
    !p3_sel_ff[3] |=> external_interrupt_one;
  endproperty
  a_p3_idle: assert property (p_p3_idle) // [RULE2]
    else $error("unselected interrupt input not idle");

  property p_p1_alt1;
    @(posedge clock) disable iff (!rst_n_ff)
    p1_lo_ff[2] && !p1_hi_ff[2] && !(p4_lo_ff[2] && p4_hi_ff[2])
      |=> serial1_receive == $past(port1_pin_level[2]);
  endproperty
  a_p1_alt1: assert property (p_p1_alt1) // [RULE3]
    else $error("port 1 alternate 1 decode wrong");

  property p_analog_sel;
    @(posedge clock) disable iff (!rst_n_ff)
    ##1 analog_select == $past(p1_lo_ff & p1_hi_ff);
  endproperty
  a_analog_sel: assert property (p_analog_sel) // [RULE5]
    else $error("analog channel select wrong");

  property p_p4_module;
    @(posedge clock) disable iff (!rst_n_ff)
    p4_lo_ff[0] && !p4_hi_ff[0]
      |=> array_module_in[0] == $past(port4_pin_level[0]);
  endproperty
  a_p4_module: assert property (p_p4_module) // [RULE6]
    else $error("counter module input not routed");

  property p_p4_spi;
    @(posedge clock) disable iff (!rst_n_ff)
    p4_lo_ff[5] && p4_hi_ff[5] && !(p1_lo_ff[5] && !p1_hi_ff[5])
      |=> spi_receive_in == $past(port4_pin_level[5]);
  endproperty
  a_p4_spi: assert property (p_p4_spi) // [RULE7]
    else $error("port 4 SPI receive not routed");

  property p_wr_p1;
    @(posedge clock) disable iff (!rst_n_ff)
    sfr_wr && sfr_addr == pafm_pkg::ADDR_P1_LO ##1 !sfr_wr
      ##1 sfr_rd && sfr_addr == pafm_pkg::ADDR_P1_LO && !sfr_wr
      |=> sfr_rdata == $past(sfr_wdata, 3);
  endproperty
  a_wr_p1: assert property (p_wr_p1) // [RULE8]
    else $error("port 1 low select readback wrong");

  property p_wr_p4;
    @(posedge clock) disable iff (!rst_n_ff)
    sfr_wr && sfr_addr == pafm_pkg::ADDR_P4_HI
      |=> p4_hi_ff == $past(sfr_wdata);
  endproperty
  a_wr_p4: assert property (p_wr_p4) // [RULE11]
    else $error("port 4 high select not written");

endmodule // pafm_top

// *** verification/pafm_pins.sv ***
`timescale 1ns/100ps
module pafm_pins (
  input wire logic [23:0] pout, // Pad outputs
  input wire logic [23:0] poe, // Pad drive enables
  input wire logic [23:0] ppu, // Pad pull-ups
  input wire logic [23:0] xv, // Outside level
  input wire logic [23:0] xe, // Outside drive enable
  output logic [23:0] pin // Wire level
);
  // Unheld pin with no pull-up shows the inverse, never stale data
  assign pin = xe & xv | ~xe & (poe & pout | ~poe & (ppu | ~pout));
endmodule // pafm_pins

// *** verification/port_alternate_function_mux_tb.sv ***
`timescale 1ns/100ps
module port_alternate_function_mux_tb;
  logic clock = 1'b0, reset_n = 1'b0, we = 1'b0, re = 1'b0;
  logic [7:0] addr = 8'h00, wd = 8'h00;
  logic [6:0] po = 7'h7f; // Peripheral outputs, idle high
  logic [5:0] drv = 6'h00, mo = 6'h3f;
  logic [23:0] xv = 24'h0, xe = 24'h0; // Outside pin drive
  int num_errors = 0, n_checks = 0, cyc = 0;
  wire [7:0] rd, ana;
  wire [23:0] pout, poe, ppu, pin; // Ports 1, 3, 4 from bit 0
  wire s0rx, spirx, i2cd, ei0;
  // 25 MHz clock; reset drops after three cycles
  always #20 clock = ~clock;
  initial #120 reset_n = 1'b1;
  pafm_top dut (.clock(clock), .reset_n(reset_n), .sfr_addr(addr),
    .sfr_wr(we), .sfr_rd(re), .sfr_wdata(wd), .sfr_rdata(rd),
    .port1_latch(8'hff), .port3_latch(8'hff), .port4_latch(8'hff),
    .serial0_transmit(po[0]), .serial1_transmit(po[1]),
    .i2c_data_out(po[2]), .i2c_clock_out(po[3]), .spi_clock_out(po[4]),
    .spi_transmit_out(po[5]), .spi_select_out(po[6]), .array_module_out(mo),
    .array_module_drive(drv), .serial0_receive(s0rx), .serial1_receive(),
    .external_interrupt_zero(ei0), .external_interrupt_one(),
    .counter0_input(), .counter1_input(), .i2c_data_in(i2cd),
    .i2c_clock_in(),
    .timer2_count_in(), .timer2_trigger_in(), .spi_receive_in(spirx),
    .array_module_in(), .array_zero_ext_clock(), .array_one_ext_clock(),
    .analog_select(ana), .port1_pin_in(pin[7:0]), .port1_pin_out(pout[7:0]),
    .port1_pin_oe(poe[7:0]), .port1_pullup_en(ppu[7:0]), .port1_pin_level(),
    .port3_pin_in(pin[15:8]), .port3_pin_out(pout[15:8]),
    .port3_pin_oe(poe[15:8]), .port3_pullup_en(ppu[15:8]),
    .port3_pin_level(), .port4_pin_in(pin[23:16]),
    .port4_pin_out(pout[23:16]), .port4_pin_oe(poe[23:16]),
    .port4_pullup_en(ppu[23:16]), .port4_pin_level());
  pafm_pins pins (.pout(pout), .poe(poe), .ppu(ppu), .xv(xv), .xe(xe),
    .pin(pin));
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) num_errors++;
    if (seen !== exp) $display("ERROR %0t %h exp %h", $time, seen, exp);
  endtask
  task automatic tk(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    tk(1);
    {we, re, addr, wd} = {w, ~w, a, d};
    tk(1);
    {we, re} = 2'b00;
    if (!w) chk(rd, d);
  endtask
  task automatic t_regs;
    logic [7:0] a [5] = '{8'h8e, 8'h8f, 8'h91, 8'h92, 8'h93};
    for (int i = 0; i < 5; i++) begin
      acc(1'b0, a[i], 8'h00);
      acc(1'b1, a[i], 8'h5a);
      acc(1'b0, a[i], 8'h5a);
    end
    acc(1'b0, 8'h90, 8'h00);
  endtask
  task automatic t_p3;
    {xe[8], xv[8], po[0]} = 3'b100;
    acc(1'b1, 8'h91, 8'hc3);
    tk(3);
    chk({s0rx, poe[9], pout[9]}, 3'b010);
    po[0] = 1'b1;
    tk(1);
    chk({poe[9], pout[9]}, 2'b11);
    po[2] = 1'b0;
    tk(1);
    chk({poe[9], poe[14], pout[14]}, 3'b010);
    tk(3);
    chk({i2cd, ei0}, 2'b01);
  endtask
  task automatic t_p14;
    {xe[5], xv[5], drv[0], mo[0]} = 4'b1010;
    acc(1'b1, 8'h8e, 8'h20);
    tk(4);
    chk(spirx, 1'b0);
    acc(1'b1, 8'h8f, 8'hff);
    acc(1'b1, 8'h8e, 8'hff);
    tk(3);
    chk({spirx, ana, poe[7:0], ppu[7:1]}, 24'hff8000);
    {xe[21], xv[21]} = 2'b10;
    acc(1'b1, 8'h8e, 8'h00);
    acc(1'b1, 8'h92, 8'h21);
    acc(1'b1, 8'h93, 8'h20);
    tk(4);
    chk({ana, spirx, poe[16], pout[16], ppu[16]}, 12'h004);
    mo[0] = 1'b1;
    tk(2);
    chk({poe[16], pout[16], ppu[16]}, 3'b110);
  endtask
  // Main sequence, first request well after reset leaves
  initial begin
    tk(6);
    t_regs;
    t_p3;
    t_p14;
    summarize;
  end
  task automatic summarize;
    if (cyc >= 1000) num_errors++;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard; the scenarios need under 300 cycles
  always @(posedge clock) if (++cyc == 1000) summarize;
endmodule // port_alternate_function_mux_tb
